// ==== rtl/mcp_defines.svh ====
`ifndef MCP_DEFINES_SVH
`define MCP_DEFINES_SVH

// ----------------------------------------
// Control word fields
// ----------------------------------------
`define MCP_BIT_FORCE_BUSY 12
`define MCP_BIT_ACCESSED 11
`define MCP_BIT_NEXT_BUF 10
`define MCP_BIT_BROADCAST_SEEN_FLAG_SEEN 9
`define MCP_BIT_PP_ACK 8
`define MCP_BIT_PP_SUSPEND 3
`define MCP_BIT_PP_SELECT 2
`define MCP_HOST_MASK 16'hF00C
`define MCP_DEV_MASK 16'h0F00
`define MCP_WORD_RESET 16'h0000
`define MCP_BROADCAST_SEEN_FLAG_ADDR 5'h1F

// ----------------------------------------
// Host register offsets (Wishbone)
// ----------------------------------------
`define MCP_REG_CTRL 4'h0
`define MCP_REG_WDATA 4'h4
`define MCP_REG_RDATA 4'h8
`define MCP_REG_STATUS 4'hC
`define MCP_CTRL_GO 0
`define MCP_CTRL_WE 1
`define MCP_CTRL_TERM_EN 2

`endif

// ==== rtl/mcp_pkg.sv ====
`default_nettype none
package mcp_pkg;
  typedef logic [15:0] mcp_word_t;
  typedef enum logic [0:0] {MCP_DEV_IDLE = 1'b0, MCP_DEV_MSG = 1'b1} mcp_dev_state_t;
  typedef enum logic [1:0] {
    MCP_HOST_IDLE = 2'b00,
    MCP_HOST_REQ = 2'b01,
    MCP_HOST_GAP = 2'b10
  } mcp_host_state_t;
endpackage
`default_nettype wire

// ==== rtl/mcp_if.sv ====
`default_nettype none
interface mcp_if;
  import mcp_pkg::*;
  // Host access to the control word
  logic req;
  logic we;
  mcp_word_t wdata;
  // Device answer
  logic ack;
  mcp_word_t rdata;
  modport dev (input req, input we, input wdata, output ack, output rdata);
  modport host (output req, output we, output wdata, input ack, input rdata);
endinterface
`default_nettype wire

// ==== rtl/mcp_device.sv ====
// Summary of operation
// - Set accessed flag at message completion
// - Accessed flag clears on reset or read
// - Host may poll accessed flag
// - Next-buffer bit picks pointer A or B
// - Toggle next-buffer after error-free ping-pong message
// - Hold-on-failure keeps pointer after failed messages
// - Next-buffer resets to zero, buffer A
// - Flag valid broadcast transmit mode commands
// - Broadcast disable makes address 31 invalid
// - Broadcast flag cleared only by resets
// - Ack bit driven only by device
// - Assert ack when ping-pong becomes active
// - Suspend request clears ack
// - Host services buffer only while ack low
// - Clearing suspend request reasserts ack
// - Select set, ack clear: indexed mode
// - Disable handshake leaves next-buffer unchanged
// - Select chooses ping-pong or indexed buffering
// - Host writes select only when terminal enabled
// - Busy reply: no data, no toggle
`include "mcp_defines.svh"
`default_nettype none
module mcp_device (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic soft_reset,
  // Shared word port
  mcp_if.dev mc,
  // Terminal configuration
  input wire logic cfg_broadcast_disable,
  input wire logic cfg_hold_pointer,
  input wire logic cfg_global_busy,
  // Protocol engine events
  input wire logic cmd_start,
  input wire logic [4:0] cmd_rt_addr,
  input wire logic cmd_tx,
  input wire logic msg_done,
  input wire logic msg_ok,
  input wire logic msg_illegal,
  // Buffer steering
  output logic cmd_accept,
  output logic use_pingpong,
  output logic buf_sel_b,
  output logic mode_data_tx_en,
  output logic msg_active,
  output mcp_pkg::mcp_word_t word
);
  import mcp_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  mcp_word_t word_ff, nxt_word;
  logic ack_ff, nxt_ack;
  mcp_word_t rdata_ff, nxt_rdata;
  mcp_dev_state_t state_ff, nxt_state;
  logic pp_mode_ff, nxt_pp_mode;
  logic broadcast_seen_flag_ff, nxt_broadcast_seen_flag;
  logic tx_ff, nxt_tx;

  logic to_broadcast_seen_flag;
  logic busy_eff;
  logic host_rd;
  logic host_wr;
  logic toggle;

  // ----------------------------------------
  // Host link
  // ----------------------------------------
  // Ack is a one-cycle pulse; a request still held after ack is taken again two cycles later
  always_comb
  begin
    host_rd = mc.req && !ack_ff && !mc.we;
    host_wr = mc.req && !ack_ff && mc.we;
    nxt_ack = mc.req && !ack_ff;
    nxt_rdata = rdata_ff;
    if (host_rd)
    begin
      // Word as it stood before this cycle's status update
      nxt_rdata = word_ff;
    end
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ack_ff <= 1'b0;
      rdata_ff <= 16'h0000;
    end
    else
    begin
      ack_ff <= nxt_ack;
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------
  // Combinational
  // ----------------------------------------
  always_comb
  begin
    to_broadcast_seen_flag = (cmd_rt_addr == `MCP_BROADCAST_SEEN_FLAG_ADDR);
    // Address 31 becomes an invalid command when broadcast is off
    cmd_accept = cmd_start && (state_ff == MCP_DEV_IDLE)
      && !(to_broadcast_seen_flag && cfg_broadcast_disable);
    busy_eff = word_ff[`MCP_BIT_FORCE_BUSY] || cfg_global_busy;
    // Non-busy ping-pong messages move the pointer when error-free, or when illegal with hold off
    toggle = pp_mode_ff && !busy_eff
      && (msg_ok || (msg_illegal && !cfg_hold_pointer));

    nxt_word = word_ff;
    nxt_state = state_ff;
    nxt_pp_mode = pp_mode_ff;
    nxt_broadcast_seen_flag = broadcast_seen_flag_ff;
    nxt_tx = tx_ff;

    if (host_rd)
    begin
      nxt_word[`MCP_BIT_ACCESSED] = 1'b0;
    end
    if (host_wr)
    begin
      // Host reaches only its own bits; status bits stay device-owned
      nxt_word = (word_ff & ~`MCP_HOST_MASK) | (mc.wdata & `MCP_HOST_MASK);
    end

    case (state_ff)
      MCP_DEV_IDLE:
      begin
        // Ack follows the host only between messages, so a buffer
        // swap never lands in the middle of a transfer
        nxt_word[`MCP_BIT_PP_ACK] = word_ff[`MCP_BIT_PP_SELECT]
          && !word_ff[`MCP_BIT_PP_SUSPEND];
        if (cmd_accept)
        begin
          nxt_state = MCP_DEV_MSG;
          nxt_pp_mode = word_ff[`MCP_BIT_PP_SELECT]
            && word_ff[`MCP_BIT_PP_ACK];
          nxt_broadcast_seen_flag = to_broadcast_seen_flag;
          nxt_tx = cmd_tx;
        end
      end
      MCP_DEV_MSG:
      begin
        if (msg_done)
        begin
          nxt_state = MCP_DEV_IDLE;
          // One update of the status bits, host bits as merged above
          nxt_word[`MCP_BIT_ACCESSED] = 1'b1;
          if (toggle)
          begin
            nxt_word[`MCP_BIT_NEXT_BUF] = !word_ff[`MCP_BIT_NEXT_BUF];
          end
          if (broadcast_seen_flag_ff && tx_ff && msg_ok && !cfg_broadcast_disable)
          begin
            nxt_word[`MCP_BIT_BROADCAST_SEEN_FLAG_SEEN] = 1'b1;
          end
        end
      end
      default:
      begin
        nxt_state = MCP_DEV_IDLE;
      end
    endcase

    // Unused bits read as zero
    nxt_word = nxt_word & (`MCP_HOST_MASK | `MCP_DEV_MASK);

    if (soft_reset)
    begin
      nxt_word = `MCP_WORD_RESET;
      nxt_state = MCP_DEV_IDLE;
      nxt_pp_mode = 1'b0;
    end
  end

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      word_ff <= `MCP_WORD_RESET;
      state_ff <= MCP_DEV_IDLE;
      pp_mode_ff <= 1'b0;
      broadcast_seen_flag_ff <= 1'b0;
      tx_ff <= 1'b0;
    end
    else
    begin
      word_ff <= nxt_word;
      state_ff <= nxt_state;
      pp_mode_ff <= nxt_pp_mode;
      broadcast_seen_flag_ff <= nxt_broadcast_seen_flag;
      tx_ff <= nxt_tx;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign mc.ack = ack_ff;
  assign mc.rdata = rdata_ff;
  assign word = word_ff;
  assign msg_active = (state_ff == MCP_DEV_MSG);
  assign use_pingpong = pp_mode_ff;
  // Pointer B when set; also used in indexed fallback
  assign buf_sel_b = word_ff[`MCP_BIT_NEXT_BUF];
  assign mode_data_tx_en = !busy_eff;

endmodule
`default_nettype wire

// ==== rtl/mcp_host.sv ====
`include "mcp_defines.svh"
`default_nettype none
module mcp_host (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rstn,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Shared word port
  mcp_if.host mc
);
  import mcp_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic wb_ack_ff, nxt_wb_ack;
  logic [31:0] wb_dat_ff, nxt_wb_dat;
  logic term_en_ff, nxt_term_en;
  logic we_ff, nxt_we;
  mcp_word_t wdata_ff, nxt_wdata;
  mcp_word_t last_ff, nxt_last;
  mcp_host_state_t state_ff, nxt_state;
  logic go;
  logic wb_hit;
  logic busy;

  always_comb
  begin
    wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_ff;
    busy = (state_ff != MCP_HOST_IDLE);
    go = 1'b0;
    nxt_wb_ack = wb_hit;
    nxt_wb_dat = 32'h0000_0000;
    nxt_term_en = term_en_ff;
    nxt_we = we_ff;
    nxt_wdata = wdata_ff;
    nxt_last = last_ff;
    nxt_state = state_ff;

    if (wb_hit && wb_we_i)
    begin
      if (wb_adr_i == `MCP_REG_CTRL)
      begin
        if (wb_sel_i[0])
        begin
          // Enable held during an access so the sent word cannot shift
          if (!busy)
          begin
            nxt_term_en = wb_dat_i[`MCP_CTRL_TERM_EN];
          end
          // A new access is dropped while one is still open
          go = wb_dat_i[`MCP_CTRL_GO] && !busy;
          if (go)
          begin
            nxt_we = wb_dat_i[`MCP_CTRL_WE];
          end
        end
      end
      else if (wb_adr_i == `MCP_REG_WDATA && !busy)
      begin
        if (wb_sel_i[0])
        begin
          nxt_wdata[7:0] = wb_dat_i[7:0];
        end
        if (wb_sel_i[1])
        begin
          nxt_wdata[15:8] = wb_dat_i[15:8];
        end
      end
    end
    else if (wb_hit)
    begin
      if (wb_adr_i == `MCP_REG_CTRL)
      begin
        nxt_wb_dat = {29'h0, term_en_ff, we_ff, 1'b0};
      end
      else if (wb_adr_i == `MCP_REG_WDATA)
      begin
        nxt_wb_dat = {16'h0000, wdata_ff};
      end
      else if (wb_adr_i == `MCP_REG_RDATA)
      begin
        nxt_wb_dat = {16'h0000, last_ff};
      end
      else if (wb_adr_i == `MCP_REG_STATUS)
      begin
        // Bit 1: buffer safe to service while ack reads low
        nxt_wb_dat = {30'h0, !last_ff[`MCP_BIT_PP_ACK], busy};
      end
    end

    case (state_ff)
      MCP_HOST_IDLE:
      begin
        if (go)
        begin
          nxt_state = MCP_HOST_REQ;
        end
      end
      MCP_HOST_REQ:
      begin
        if (mc.ack)
        begin
          nxt_state = MCP_HOST_GAP;
          if (!we_ff)
          begin
            nxt_last = mc.rdata;
          end
        end
      end
      MCP_HOST_GAP:
      begin
        nxt_state = MCP_HOST_IDLE;
      end
      default:
      begin
        nxt_state = MCP_HOST_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk or negedge rstn)
  begin
    if (!rstn)
    begin
      wb_ack_ff <= 1'b0;
      wb_dat_ff <= 32'h0000_0000;
      term_en_ff <= 1'b0;
      we_ff <= 1'b0;
      wdata_ff <= 16'h0000;
      last_ff <= 16'h0000;
      state_ff <= MCP_HOST_IDLE;
    end
    else
    begin
      wb_ack_ff <= nxt_wb_ack;
      wb_dat_ff <= nxt_wb_dat;
      term_en_ff <= nxt_term_en;
      we_ff <= nxt_we;
      wdata_ff <= nxt_wdata;
      last_ff <= nxt_last;
      state_ff <= nxt_state;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign wb_ack_o = wb_ack_ff;
  assign wb_dat_o = wb_dat_ff;
  assign mc.req = (state_ff == MCP_HOST_REQ);
  assign mc.we = we_ff;
  // Status bits never sent; select held at last read unless terminal enabled
  always_comb
  begin
    mc.wdata = wdata_ff & `MCP_HOST_MASK;
    if (!term_en_ff)
    begin
      mc.wdata[`MCP_BIT_PP_SELECT] = last_ff[`MCP_BIT_PP_SELECT];
    end
  end

endmodule
`default_nettype wire

// ==== tb/mcp_props.sv ====
`include "mcp_defines.svh"
`default_nettype none
module mcp_props (
  // Clock and resets
  input wire logic sys_clk,
  input wire logic rstn,
  input wire logic soft_reset,
  input wire logic msg_active,
  // Link
  input wire logic req,
  input wire logic we,
  input wire mcp_pkg::mcp_word_t wdata,
  input wire logic ack,
  input wire mcp_pkg::mcp_word_t rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import mcp_pkg::*;
  // ----------------------------------------
  // Shadow of host bits and completions
  // ----------------------------------------
  mcp_word_t host_ff, nxt_host;
  logic done_ff, nxt_done, act_ff;
  always_comb
  begin
    nxt_host = host_ff;
    nxt_done = done_ff;
    if (ack && !we)
      nxt_done = 1'b0;
    // Completion wins over a read in the same cycle
    if (act_ff && !msg_active)
      nxt_done = 1'b1;
    if (ack && we)
      nxt_host = wdata & `MCP_HOST_MASK;
    if (soft_reset)
    begin
      nxt_host = '0;
      nxt_done = 1'b0;
    end
  end
  always_ff @(posedge sys_clk or negedge rstn)
    if (!rstn)
    begin
      host_ff <= '0;
      done_ff <= 1'b0;
      act_ff <= 1'b0;
    end
    else
    begin
      host_ff <= nxt_host;
      done_ff <= nxt_done;
      act_ff <= msg_active;
    end
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rstn);
  ack_answer_a: assert property (req && !ack |=> ack) else $error("no ack");
  ack_pulse_a: assert property (ack |=> !ack && !req) else $error("ack or req held");
  req_hold_a: assert property (req && !ack |=> req && $stable(we) && $stable(wdata))
    else $error("request changed");
  host_mask_a: assert property (req && we |-> (wdata & ~`MCP_HOST_MASK) == 16'h0000)
    else $error("host wrote device bits");
  unused_zero_a: assert property (ack && !we |-> (rdata & 16'h00F3) == 16'h0000)
    else $error("unused bits set");
  rdata_hold_a: assert property ($changed(rdata) |-> ack && !we)
    else $error("rdata moved");
  host_bits_kept_a: assert property (ack && !we |-> (rdata & `MCP_HOST_MASK) == host_ff)
    else $error("host bits lost");
  read_clear_a: assert property (ack && !we && rdata[11] |-> done_ff)
    else $error("accessed flag stale");
  cover property (ack && we);
  cover property (ack && !we && rdata[8]);
  cover property (ack && !we && rdata[9]);
endmodule
`default_nettype wire

// ==== tb/mcp_tb.sv ====
`include "mcp_defines.svh"
`default_nettype none
module mcp_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mcp_pkg::*;
  logic sys_clk, rstn, soft_reset, bc_dis, hold, gbusy, cmd_start, cmd_tx;
  logic msg_done, msg_ok, msg_ill, cyc, stb, wwe, wack, accept, use_pp, sel_b;
  logic tx_en, active;
  logic [4:0] rt_addr;
  logic [3:0] adr, sel;
  logic [31:0] dat_i, dat_o, q;
  mcp_word_t word;
  int bad_count, check_count;
  mcp_if mc ();
  mcp_device mcp_device_i (.sys_clk(sys_clk), .rstn(rstn), .soft_reset(soft_reset),
    .mc(mc), .cfg_broadcast_disable(bc_dis), .cfg_hold_pointer(hold),
    .cfg_global_busy(gbusy), .cmd_start(cmd_start), .cmd_rt_addr(rt_addr),
    .cmd_tx(cmd_tx), .msg_done(msg_done), .msg_ok(msg_ok), .msg_illegal(msg_ill),
    .cmd_accept(accept), .use_pingpong(use_pp), .buf_sel_b(sel_b),
    .mode_data_tx_en(tx_en), .msg_active(active), .word(word));
  mcp_host mcp_host_i (.sys_clk(sys_clk), .rstn(rstn), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(wwe), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat_i), .wb_dat_o(dat_o),
    .wb_ack_o(wack), .mc(mc));
  mcp_props mcp_props_i (.sys_clk(sys_clk), .rstn(rstn), .soft_reset(soft_reset),
    .msg_active(active), .req(mc.req), .we(mc.we), .wdata(mc.wdata), .ack(mc.ack),
    .rdata(mc.rdata));
  // ----------------------------------------
  // Checks and bus tasks
  // ----------------------------------------
  task automatic chk_word(input mcp_word_t got, input mcp_word_t exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t word %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_bit(input logic got, input logic exp);
    check_count++;
    if (got !== exp)
    begin
      bad_count++;
      $display("ERROR %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Hang guard shared by every wait
  task automatic guard(input int n);
    if (n > 50)
    begin
      bad_count++;
      report_and_stop();
    end
  endtask
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    wwe <= w;
    adr <= a;
    dat_i <= d;
    n = 0;
    @(posedge sys_clk);
    while (wack !== 1'b1)
    begin
      n++;
      guard(n);
      @(posedge sys_clk);
    end
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask
  task automatic wait_idle;
    int n;
    n = 0;
    q = 32'h00000001;
    while (q[0] !== 1'b0)
    begin
      wb(1'b0, `MCP_REG_STATUS, 32'h00000000);
      n++;
      guard(n);
    end
  endtask
  task automatic wr_word(input mcp_word_t w);
    wb(1'b1, `MCP_REG_WDATA, {16'h0000, w});
    wb(1'b1, `MCP_REG_CTRL, 32'h00000007);
    wait_idle();
  endtask
  task automatic rd_word(input mcp_word_t exp);
    wb(1'b1, `MCP_REG_CTRL, 32'h00000005);
    wait_idle();
    wb(1'b0, `MCP_REG_RDATA, 32'h00000000);
    chk_word(q[15:0], exp);
  endtask
  // Fixed spacing follows the device's message walk
  task automatic msg(input logic [4:0] a, input logic ok, input logic ill, input logic pp);
    @(posedge sys_clk);
    cmd_start <= 1'b1;
    rt_addr <= a;
    @(posedge sys_clk);
    chk_bit(accept, 1'b1);
    cmd_start <= 1'b0;
    msg_done <= 1'b1;
    msg_ok <= ok;
    msg_ill <= ill;
    @(posedge sys_clk);
    chk_bit(use_pp, pp);
    chk_bit(active, 1'b1);
    msg_done <= 1'b0;
    repeat (2) @(posedge sys_clk);
    chk_bit(active, 1'b0);
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial
  begin
    {rstn, soft_reset, bc_dis, hold, gbusy, cmd_start, msg_done, msg_ok, msg_ill} = '0;
    {cyc, stb, wwe, adr, dat_i, rt_addr} = '0;
    cmd_tx = 1'b1;
    sel = 4'hF;
    bad_count = 0;
    check_count = 0;
    repeat (2) @(posedge sys_clk);
    rstn <= 1'b1;
    @(posedge sys_clk);
    chk_bit(sel_b, 1'b0);
    chk_bit(tx_en, 1'b1);
    rd_word(16'h0000);
    wr_word(16'h0F04);
    rd_word(16'h0104);
    msg(5'h01, 1'b1, 1'b0, 1'b1);
    chk_bit(sel_b, 1'b1);
    rd_word(16'h0D04);
    rd_word(16'h0504);
    wr_word(16'h1004);
    chk_bit(tx_en, 1'b0);
    msg(5'h01, 1'b1, 1'b0, 1'b1);
    rd_word(16'h1D04);
    wr_word(16'h0004);
    gbusy <= 1'b1;
    hold <= 1'b1;
    @(posedge sys_clk);
    chk_bit(tx_en, 1'b0);
    gbusy <= 1'b0;
    msg(5'h01, 1'b0, 1'b1, 1'b1);
    chk_bit(sel_b, 1'b1);
    hold <= 1'b0;
    msg(5'h01, 1'b0, 1'b1, 1'b1);
    rd_word(16'h0904);
    wr_word(16'h000C);
    rd_word(16'h000C);
    wb(1'b0, `MCP_REG_STATUS, 32'h00000000);
    chk_bit(q[1], 1'b1);
    msg(5'h01, 1'b1, 1'b0, 1'b0);
    rd_word(16'h080C);
    wr_word(16'h0004);
    rd_word(16'h0104);
    msg(5'h1F, 1'b1, 1'b0, 1'b1);
    rd_word(16'h0F04);
    rd_word(16'h0704);
    bc_dis <= 1'b1;
    cmd_start <= 1'b1;
    @(posedge sys_clk);
    chk_bit(accept, 1'b0);
    cmd_start <= 1'b0;
    soft_reset <= 1'b1;
    @(posedge sys_clk);
    soft_reset <= 1'b0;
    bc_dis <= 1'b0;
    @(posedge sys_clk);
    chk_word(word, 16'h0000);
    msg(5'h01, 1'b1, 1'b0, 1'b0);
    chk_bit(sel_b, 1'b0);
    cmd_tx <= 1'b0;
    msg(5'h1F, 1'b1, 1'b0, 1'b0);
    rd_word(16'h0800);
    wb(1'b0, 4'h2, 32'h00000000);
    chk_word(q[15:0], 16'h0000);
    report_and_stop();
  end
endmodule
`default_nettype wire
